// file: usb_core_reset_pkg.sv
`default_nettype none
package usb_core_reset_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] RESET_CTRL_OFFSET  = 12'h010;
  localparam logic [11:0] EVENT_FLAGS_OFFSET = 12'h014;
  localparam logic [31:0] RESET_CTRL_RESET   = 32'h8000_0000;
  localparam logic [31:0] EVENT_FLAGS_RESET  = 32'h0400_0021;
  localparam logic [31:0] EVENT_FLAGS_FIXED  = 32'h0000_0021;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SEL_LSB            = 6;
  localparam int SEL_MSB            = 10;
  localparam int TX_FLUSH_BIT       = 5;
  localparam int RX_FLUSH_BIT       = 4;
  localparam int FRAME_RESET_BIT    = 2;
  localparam int BUS_RESET_BIT      = 1;
  localparam int CORE_RESET_BIT     = 0;
  localparam int IDLE_BIT           = 31;
  localparam int WAKEUP_BIT         = 31;
  localparam int SESSION_BIT        = 30;
  localparam int DISCONNECT_BIT     = 29;
  localparam int ID_CHANGE_BIT      = 28;
  localparam int PERIODIC_EMPTY_BIT = 26;
  localparam int CHANNEL_BIT        = 25;
  localparam int DEVICE_TX_FIFOS    = 4;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int ACTION_TIME_NS  = 40;
  localparam int ACTION_CYCLES   =
    (ACTION_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [7:0] ACTION_LAST = 8'(ACTION_CYCLES - 1);
  localparam logic [4:0] SEL_RESET   = 5'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {CTRL_IDLE, CTRL_BUSY} ctrl_state_type;

  typedef struct packed {
    logic hostMode;
    logic resumeSeen;
    logic remoteWakeSeen;
    logic sessionRequestSeen;
    logic bDevice;
    logic vbusValid;
    logic disconnectSeen;
    logic idPin;
    logic periodicFifoHalfEmpty;
    logic periodicFifoEmpty;
    logic periodicFifoThreshold;
    logic anyChannelIrq;
  } usb_events_type;

  typedef struct packed {
    logic [3:0] txFifoFlush;
    logic       rxFifoFlush;
    logic       frameCounterClear;
    logic       busDomainReset;
    logic       usbDomainReset;
  } core_actions_type;

  typedef struct packed {
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    ctrl_state_type   ctrlState;
    logic [7:0]       count;
    logic [4:0]       flushSel;
    logic             txFlush;
    logic             rxFlush;
    logic             frameReset;
    logic             busReset;
    logic             coreReset;
    logic             wakeup;
    logic             session;
    logic             disconnect;
    logic             idChange;
    logic             idPrev;
    logic             idValid;
    logic             vbusPrev;
    logic             periodicEmpty;
    logic             channelSummary;
    core_actions_type actions;
  } block_state_type;

endpackage
`default_nettype wire

// file: usb_core_reset_and_irq_flags.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module usb_core_reset_and_irq_flags
  import usb_core_reset_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire usb_events_type   events,
  output core_actions_type      actions
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] byteMask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Whole-word decode: byte lanes of a word never select another register
  function automatic logic regHit(
    input logic [11:0] addr,
    input logic [11:0] offset
  );
    return addr[11:2] == offset[11:2];
  endfunction

  // ----------------------------------------
  // Flag and action helpers
  // ----------------------------------------
  function automatic logic [3:0] txFifoMask(
    input logic [4:0] sel,
    input logic       host
  );
    logic [3:0] m;
    m = '0;
    if (host) begin
      if (sel[4]) begin
        m = 4'h3;
      end else if (sel == 5'h00) begin
        m = 4'h1;
      end else if (sel == 5'h01) begin
        m = 4'h2;
      end
    end else begin
      if (sel[4]) begin
        m = 4'hF;
      end else if (sel < 5'(DEVICE_TX_FIFOS)) begin
        m = 4'(4'h1 << sel[1:0]);
      end
    end
    return m;
  endfunction

  // Set beats clear so no event is lost
  function automatic logic flagNext(
    input logic cur,
    input logic set,
    input logic clr
  );
    return set | (cur & ~clr);
  endfunction

  // Sources of the four sticky flags, in register bit order 31..28
  function automatic logic [3:0] eventSets(
    input usb_events_type ev,
    input logic           vbusPrev,
    input logic           idPrev,
    input logic           idValid
  );
    logic [3:0] s;
    s    = '0;
    s[3] = ev.hostMode ? ev.remoteWakeSeen : ev.resumeSeen;
    s[2] = ev.bDevice ? (ev.vbusValid & ~vbusPrev)
                      : ev.sessionRequestSeen;
    s[1] = ev.hostMode & ev.disconnectSeen;
    s[0] = idValid & (ev.idPin != idPrev);
    return s;
  endfunction

  // Core strobes follow the latched action bits, except that a core reset also drives the bus domain reset
  function automatic core_actions_type actionStrobes(
    input logic       tx,
    input logic       rx,
    input logic       frame,
    input logic       bus,
    input logic       core,
    input logic [4:0] sel,
    input logic       host
  );
    core_actions_type a;
    a                   = '0;
    if (tx) begin
      a.txFifoFlush     = txFifoMask(sel, host);
    end
    a.rxFifoFlush       = rx;
    a.frameCounterClear = frame;
    a.busDomainReset    = bus | core;
    a.usbDomainReset    = core;
    return a;
  endfunction

  // Value after reset; only the periodic empty flag starts high
  function automatic block_state_type resetImage();
    block_state_type s;
    s               = '0;
    s.ctrlState     = CTRL_IDLE;
    s.flushSel      = SEL_RESET;
    s.periodicEmpty = EVENT_FLAGS_RESET[PERIODIC_EMPTY_BIT];
    return s;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  block_state_type state;
  block_state_type next_state;

  logic        setupDone;
  logic        accessEdge;
  logic        hitCtrl;
  logic        hitFlags;
  logic        ctrlWr;
  logic        flagsWr;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] ctrlRead;
  logic [31:0] flagsRead;
  logic        wakeSet;
  logic        sessSet;
  logic        discSet;
  logic        idSet;
  logic        anyAction;

  assign hitCtrl  = regHit(paddr, RESET_CTRL_OFFSET);
  assign hitFlags = regHit(paddr, EVENT_FLAGS_OFFSET);

  // ----------------------------------------
  // Read images
  // ----------------------------------------
  always_comb begin
    ctrlRead                 = '0;
    ctrlRead[IDLE_BIT]       = RESET_CTRL_RESET[IDLE_BIT];
    ctrlRead[SEL_MSB:SEL_LSB] = state.flushSel;
    ctrlRead[TX_FLUSH_BIT]   = state.txFlush;
    ctrlRead[RX_FLUSH_BIT]   = state.rxFlush;
    ctrlRead[FRAME_RESET_BIT] = state.frameReset;
    ctrlRead[BUS_RESET_BIT]  = state.busReset;
    ctrlRead[CORE_RESET_BIT] = state.coreReset;
  end

  always_comb begin
    flagsRead                     = EVENT_FLAGS_FIXED;
    flagsRead[WAKEUP_BIT]         = state.wakeup;
    flagsRead[SESSION_BIT]        = state.session;
    flagsRead[DISCONNECT_BIT]     = state.disconnect;
    flagsRead[ID_CHANGE_BIT]      = state.idChange;
    flagsRead[PERIODIC_EMPTY_BIT] = state.periodicEmpty;
    flagsRead[CHANNEL_BIT]        = state.channelSummary;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    // One wait state: pready rises in the second access cycle
    setupDone  = psel & penable & ~state.pready;
    accessEdge = psel & penable & state.pready;
    wmask      = byteMask(pstrb);
    wbits      = pwdata & wmask;
    ctrlWr     = accessEdge & pwrite & hitCtrl;
    flagsWr    = accessEdge & pwrite & hitFlags;

    next_state.pready  = setupDone;
    next_state.pslverr = 1'b0;
    next_state.prdata  = '0;
    if (setupDone) begin
      if (hitCtrl) begin
        next_state.prdata = pwrite ? 32'h0000_0000 : ctrlRead;
      end else if (hitFlags) begin
        next_state.prdata = pwrite ? 32'h0000_0000 : flagsRead;
      end else begin
        // Unmapped words answer with an error instead of stalling the bus
        next_state.pslverr = 1'b1;
      end
    end

    // ----------------------------------------
    // Event sources
    // ----------------------------------------
    {wakeSet, sessSet, discSet, idSet} =
      eventSets(events, state.vbusPrev, state.idPrev, state.idValid);

    next_state.vbusPrev = events.vbusValid;
    next_state.idPrev   = events.idPin;
    // Armed one edge late, so leaving reset fakes no ID change
    next_state.idValid  = 1'b1;

    // ----------------------------------------
    // Sticky flags, write one to clear
    // ----------------------------------------
    next_state.wakeup = flagNext(state.wakeup, wakeSet,
      flagsWr & wbits[WAKEUP_BIT]);
    next_state.session = flagNext(state.session, sessSet,
      flagsWr & wbits[SESSION_BIT]);
    next_state.disconnect = flagNext(state.disconnect, discSet,
      flagsWr & wbits[DISCONNECT_BIT]);
    next_state.idChange = flagNext(state.idChange, idSet,
      flagsWr & wbits[ID_CHANGE_BIT]);

    // ----------------------------------------
    // Live flags
    // ----------------------------------------
    // Writes have no effect on them
    next_state.periodicEmpty = events.hostMode &
      (events.periodicFifoThreshold ? events.periodicFifoEmpty
                                    : events.periodicFifoHalfEmpty);
    next_state.channelSummary =
      events.hostMode & events.anyChannelIrq;

    // ----------------------------------------
    // Action sequencer
    // ----------------------------------------
    anyAction = wbits[TX_FLUSH_BIT] | wbits[RX_FLUSH_BIT] |
                (wbits[FRAME_RESET_BIT] & events.hostMode) |
                wbits[BUS_RESET_BIT] | wbits[CORE_RESET_BIT];

    unique case (state.ctrlState)
      CTRL_IDLE: begin
        if (ctrlWr) begin
          if (pstrb[0]) begin
            next_state.flushSel[1:0] = pwdata[SEL_LSB+1:SEL_LSB];
          end
          if (pstrb[1]) begin
            next_state.flushSel[4:2] = pwdata[SEL_MSB:SEL_LSB+2];
          end
          if (anyAction) begin
            next_state.txFlush    = wbits[TX_FLUSH_BIT];
            next_state.rxFlush    = wbits[RX_FLUSH_BIT];
            next_state.frameReset = wbits[FRAME_RESET_BIT] &
                                    events.hostMode;
            next_state.busReset   = wbits[BUS_RESET_BIT];
            next_state.coreReset  = wbits[CORE_RESET_BIT];
            next_state.count      = ACTION_LAST;
            next_state.ctrlState  = CTRL_BUSY;
          end
        end
      end
      CTRL_BUSY: begin
        // Selector is frozen while an action runs, but the
        // flushed set still follows the live events.hostMode
        if (state.count == 8'h00) begin
          next_state.txFlush    = 1'b0;
          next_state.rxFlush    = 1'b0;
          next_state.frameReset = 1'b0;
          next_state.busReset   = 1'b0;
          next_state.coreReset  = 1'b0;
          next_state.ctrlState  = CTRL_IDLE;
          if (state.busReset | state.coreReset) begin
            next_state.wakeup     = 1'b0;
            next_state.session    = 1'b0;
            next_state.disconnect = 1'b0;
            next_state.idChange   = 1'b0;
          end
          if (state.coreReset) begin
            next_state.flushSel = SEL_RESET;
          end
        end else begin
          next_state.count = state.count - 8'h01;
        end
      end
    endcase

    // ----------------------------------------
    // Strobes to the core
    // ----------------------------------------
    next_state.actions = actionStrobes(next_state.txFlush, next_state.rxFlush,
      next_state.frameReset, next_state.busReset, next_state.coreReset,
      next_state.flushSel, events.hostMode);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= resetImage();
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata  = state.prdata;
  assign pready  = state.pready;
  assign pslverr = state.pslverr;
  assign actions = state.actions;

endmodule // usb_core_reset_and_irq_flags
`default_nettype wire

// file: usb_flags_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module usb_flags_monitor
  import usb_core_reset_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             reset_n,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [3:0]       pstrb,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire usb_events_type   events,
  input wire core_actions_type actions
);
  // ----------------
  // Checks
  // ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Busy writes are refused, so a start is only expected from idle
  wire logic ctlWr = pready && pwrite && paddr == 12'h010 && pstrb == 4'hF && actions == '0;
  sequence rxStart; $rose(actions.rxFifoFlush); endsequence
  sequence rxHold; actions.rxFifoFlush [*8] ##1 !actions.rxFifoFlush; endsequence

  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_map: assert property (pready && paddr[11:2] != 10'h004 && paddr[11:2] != 10'h005
    |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_rx_start: assert property (ctlWr && pwdata[4] |=> rxStart)
    else $error("receive flush not started");
  a_rx_clear: assert property (rxStart |-> rxHold)
    else $error("receive flush length wrong");
  a_tx_all: assert property (ctlWr && pwdata[5] && pwdata[10]
    |=> actions.txFifoFlush == ($past(events.hostMode) ? 4'h3 : 4'hF)) else $error("tx mask");
  a_tx_host: assert property ($rose(actions.txFifoFlush != 4'h0) && events.hostMode
    |-> actions.txFifoFlush[3:2] == 2'h0) else $error("host flush of device fifo");
  a_frame_host: assert property ($rose(actions.frameCounterClear) |-> $past(events.hostMode))
    else $error("frame reset outside host mode");
  a_core_both: assert property (actions.usbDomainReset |-> actions.busDomainReset)
    else $error("core reset misses bus domain");
endmodule // usb_flags_monitor

bind usb_core_reset_and_irq_flags usb_flags_monitor u_usb_flags_monitor (
  .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .events(events), .actions(actions)
);
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import usb_core_reset_pkg::*;
;
  logic             ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [3:0]       pstrb;
  usb_events_type   events;
  core_actions_type actions;
  int               nMismatch, checkCount, k;
  logic [12:0]      md = 13'h0F0F;
  logic [11:0]      dv [13] = '{12'h020, 12'h060, 12'h420, 12'h0A0, 12'h020, 12'h0E0,
                                12'h7E0, 12'h120, 12'h010, 12'h004, 12'h002, 12'h001, 12'h004};
  logic [7:0]       ev [13] = '{8'h10, 8'h20, 8'h30, 8'h00, 8'h10, 8'h80, 8'hF0, 8'h00,
                                8'h08, 8'h04, 8'h02, 8'h03, 8'h00};

  usb_core_reset_and_irq_flags u_usb_core_reset_and_irq_flags (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .events(events), .actions(actions)
  );

  // ----------------
  // Tasks
  // ----------------
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic finalReport();
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Idle cycle at the end keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (!pready && i < 20);
    rd = prdata;
    err = pslverr;
    check("apb wait", 32'(pready), 32'h1);
    if (pready !== 1'b1) finalReport();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd, e);
  endtask

  task automatic act(input logic [31:0] d, input logic [7:0] e);
    apb(1'b1, 12'h010, d);
    #1;
    check("actions", 32'(actions), 32'(e));
    @(posedge ref_clk);
  endtask

  // Polls instead of waiting a fixed time: the action length is the design's choice
  task automatic settle();
    int i;
    for (i = 0; i < 10; i++) begin
      apb(1'b0, 12'h010, 32'h0);
      if (rd[5:0] === 6'h00) break;
    end
    check("ctrl idle", rd & 32'h0000_003F, 32'h0);
    check("actions idle", 32'(actions), 32'h0);
    if (rd[5:0] !== 6'h00) finalReport();
  endtask

  task automatic pulse(input logic [11:0] m);
    events <= events ^ m;
    @(posedge ref_clk);
    events <= events ^ m;
    @(posedge ref_clk);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, nMismatch, checkCount} = '0;
    pstrb = 4'hF;
    events = '0;
    events.hostMode = 1'b1;
    events.periodicFifoHalfEmpty = 1'b1;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rdc(12'h010, 32'h8000_0000);
    rdc(12'h014, 32'h0400_0021);
    apb(1'b0, 12'h018, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    $display("test reset done");
    act(32'h20, 8'h10);
    apb(1'b1, 12'h010, 32'h10);
    #1;
    check("busy write", 32'(actions), 32'h10);
    @(posedge ref_clk);
    settle();
    for (k = 0; k < 13; k++) begin
      events.hostMode <= md[k];
      @(posedge ref_clk);
      act({20'h0, dv[k]}, ev[k]);
      settle();
    end
    $display("test actions done");
    events.hostMode <= 1'b1;
    @(posedge ref_clk);
    pulse(12'h330);
    rdc(12'h014, 32'hF400_0021);
    apb(1'b1, 12'h014, 32'h8600_0000);
    rdc(12'h014, 32'h7400_0021);
    events.periodicFifoThreshold <= 1'b1;
    rdc(12'h014, 32'h7000_0021);
    events.periodicFifoEmpty <= 1'b1;
    events.anyChannelIrq <= 1'b1;
    rdc(12'h014, 32'h7600_0021);
    events.anyChannelIrq <= 1'b0;
    rdc(12'h014, 32'h7400_0021);
    $display("test host flags done");
    events.hostMode <= 1'b0;
    // Resume only on the clearing write's edge: bit 31 survives only if the set wins
    fork
      apb(1'b1, 12'h014, 32'hF000_0000);
      begin
        repeat (2) @(posedge ref_clk);
        events.resumeSeen <= 1'b1;
        @(posedge ref_clk);
        events.resumeSeen <= 1'b0;
      end
    join
    @(posedge ref_clk);
    pulse(12'h020);
    rdc(12'h014, 32'h8000_0021);
    events.bDevice <= 1'b1;
    @(posedge ref_clk);
    pulse(12'h040);
    rdc(12'h014, 32'hC000_0021);
    pstrb <= 4'h7;
    apb(1'b1, 12'h014, 32'hC000_0000);
    pstrb <= 4'hF;
    rdc(12'h014, 32'hC000_0021);
    act(32'h2, 8'h02);
    settle();
    rdc(12'h014, 32'h0000_0021);
    $display("test device flags done");
    finalReport();
  end
endmodule // testbench
`default_nettype wire
